// file: hw/cssq_pkg.sv
// package: constants and types for the clock source start-up sequencer
package cssq_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_FUSE = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_TOUT = 8'h0C;
   localparam logic [7:0] OFS_SUCNT = 8'h10;
   localparam logic [2:0] SIZE_WORD = 3'h2;
   // control register bit positions
   localparam int CTRL_PDOWN = 0;
   localparam int CTRL_NOISE = 1;
   // synchroniser lanes
   localparam int SY_EXT = 0;
   localparam int SY_BOD = 1;
   localparam int SY_WDT = 2;
   localparam int SY_OSC = 3;
   localparam int SY_WAKE = 4;
   localparam int SY_W = 5;
   // oscillator cycle counts
   localparam logic [15:0] SU_258 = 16'h0102;
   localparam logic [15:0] SU_1K = 16'h0400;
   localparam logic [15:0] SU_EXT = 16'h0006;
   localparam logic [15:0] RST_EXTRA = 16'h000E;
   // watchdog cycle count of the short time-out
   localparam logic [13:0] TOUT_512 = 14'h0200;
   // fuse image, a one means unprogrammed
   typedef struct packed {
      logic div8_n;
      logic [1:0] sut;
      logic [3:0] sel;
   } cssq_fuse_s;
   // shipped setting: rc oscillator, sut 10, divide by eight programmed
   localparam cssq_fuse_s FUSE_RESET = '{div8_n: 1'b0, sut: 2'h2, sel: 4'h2};
   typedef enum logic [2:0] {SRC_LP, SRC_FS, SRC_LF, SRC_IRC128, SRC_RC, SRC_EXT, SRC_NONE} cssq_src_e;
   // decoded fuse configuration
   typedef struct packed {
      cssq_src_e src;
      logic [1:0] range;
      logic [15:0] wake;
      logic [13:0] tout;
      logic resv;
   } cssq_cfg_s;
   typedef enum logic [2:0] {ST_HOLD, ST_TIMEOUT, ST_STARTUP, ST_RUN, ST_NOISE, ST_PDOWN, ST_BADSEL} cssq_state_e;
   // complete state of the top module
   typedef struct packed {
      cssq_state_e state;
      logic from_reset;
      cssq_fuse_s snap;
      cssq_fuse_s fuse;
      logic [13:0] tout_cnt;
      logic [15:0] su_cnt;
      logic ap_valid;
      logic ap_write;
      logic ap_hit;
      logic ap_word;
      logic [7:0] ap_addr;
      logic [31:0] hrdata;
      logic hreadyout;
      logic core_reset;
      logic cpu_en;
      logic adc_en;
      logic osc_en;
      cssq_src_e src;
      logic [1:0] range;
      logic div8;
   } cssq_top_s;
   localparam cssq_top_s TOP_RESET = '{state: ST_HOLD, fuse: FUSE_RESET, snap: FUSE_RESET, hreadyout: 1'b1,
      core_reset: 1'b1, osc_en: 1'b1, src: SRC_RC, default: '0};
endpackage

// file: hw/cssq_sync.sv
// module: two-flop synchronisers with rising edge detect
`timescale 1ns/1ps
`default_nettype none
module cssq_sync #(
   parameter int W = 5
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_level,
   output logic [W-1:0] o_rise
);
   // meta stage, second stage, edge history
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
      logic [W-1:0] prev;
   } cssq_sync_s;
   cssq_sync_s q;
   cssq_sync_s next_q;
   // meta is only ever read by the sync stage
   always_comb begin
      next_q.meta = i_async;
      next_q.sync = q.meta;
      next_q.prev = q.sync;
   end
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end
   assign o_level = q.sync;
   assign o_rise = q.sync & ~q.prev;
endmodule
`default_nettype wire

// file: hw/cssq_fuse_decode.sv
// module: fuse decode into clock source and start-up counts
`timescale 1ns/1ps
`default_nettype none
module cssq_fuse_decode #(
   parameter logic [13:0] TOUT_LONG = 14'h2000,
   parameter logic [15:0] SU_16K = 16'h4000,
   parameter logic [15:0] SU_32K = 16'h8000
) (
   input wire cssq_pkg::cssq_fuse_s i_fuse,
   output var cssq_pkg::cssq_cfg_s o_cfg
);
   import cssq_pkg::*;
   // time-out select: 0, 512 or long watchdog cycles
   function automatic logic [13:0] tout_sel(input logic [1:0] k);
      unique case (k)
         2'h1: tout_sel = TOUT_512;
         2'h2: tout_sel = TOUT_LONG;
         default: tout_sel = 14'h0000;
      endcase
   endfunction
   logic [2:0] idx;
   assign idx = {i_fuse.sel[0], i_fuse.sut};
   // zero fuse bits select, read as programmed
   always_comb begin
      o_cfg = '0;
      o_cfg.src = SRC_NONE;
      unique casez (i_fuse.sel)
         4'b1???, 4'b011?: begin
            // crystal tables shared by low power and full swing
            o_cfg.src = i_fuse.sel[3] ? SRC_LP : SRC_FS;
            o_cfg.range = i_fuse.sel[3] ? i_fuse.sel[2:1] : 2'h0;
            unique case (idx)
               3'h0: {o_cfg.wake, o_cfg.tout} = {SU_258, tout_sel(2'h1)};
               3'h1: {o_cfg.wake, o_cfg.tout} = {SU_258, tout_sel(2'h2)};
               3'h2: {o_cfg.wake, o_cfg.tout} = {SU_1K, tout_sel(2'h0)};
               3'h3: {o_cfg.wake, o_cfg.tout} = {SU_1K, tout_sel(2'h1)};
               3'h4: {o_cfg.wake, o_cfg.tout} = {SU_1K, tout_sel(2'h2)};
               3'h5: {o_cfg.wake, o_cfg.tout} = {SU_16K, tout_sel(2'h0)};
               3'h6: {o_cfg.wake, o_cfg.tout} = {SU_16K, tout_sel(2'h1)};
               3'h7: {o_cfg.wake, o_cfg.tout} = {SU_16K, tout_sel(2'h2)};
            endcase
         end
         4'b010?: begin
            // watch crystal, sut 11 is reserved
            o_cfg.src = SRC_LF;
            o_cfg.wake = idx[2] ? SU_32K : SU_1K;
            o_cfg.tout = tout_sel(idx[1:0]);
            o_cfg.resv = (idx[1:0] == 2'h3);
         end
         4'b0011, 4'b0010, 4'b0000: begin
            // internal and external clocks need only a short count
            unique casez (i_fuse.sel)
               4'b0011: o_cfg.src = SRC_IRC128;
               4'b0010: o_cfg.src = SRC_RC;
               default: o_cfg.src = SRC_EXT;
            endcase
            o_cfg.wake = SU_EXT;
            o_cfg.tout = tout_sel(i_fuse.sut);
            o_cfg.resv = (i_fuse.sut == 2'h3);
         end
         4'b0001: begin
            o_cfg.resv = 1'b1;
         end
      endcase
   end
endmodule
`default_nettype wire

// file: hw/cssq_top.sv
// module: clock source selection and internal reset start-up sequencer
`timescale 1ns/1ps
`default_nettype none
// Operation
// - fuse bit one unprogrammed, zero programmed
// - codes 1xxx low power, 011x full swing
// - low frequency, 128k, rc and external codes
// - code 0001 reserved, selects no source
// - shipped default rc, sut 10, divide on
// - time-out starts after all resets release
// - time-out counted in watchdog cycles, fuse chosen
// - time-out lengths 0, 512 or 8192 cycles
// - ripple count holds reset, then release
// - reset: time-out plus count; power-down wake: count only
// - start-up counts from 6 to 32K
// - brown-out holds reset, time-out may be zero
// - low power range from upper three bits
// - divide fuse programmed divides clock by 8
// - low power start-up from low bit, sut
// - low bit 0, sut 00/01: 258 cycles
// - 1K cycle options with 14 or time-out
// - low bit 1, sut 01/10/11: 16K cycle options
// - converter clock runs while cpu halted in noise reduction
// - selected source feeds the clock generator
module cssq_top #(
   parameter logic [13:0] TOUT_LONG = 14'h2000, // long time-out, watchdog cycles
   parameter logic [15:0] SU_16K = 16'h4000, // crystal wake count
   parameter logic [15:0] SU_32K = 16'h8000 // watch crystal wake count
) (
   input wire logic I_CORE_CLK,
   input wire logic I_RST,
   input wire logic I_EXT_RESET,
   input wire logic I_BROWNOUT,
   input wire logic I_WDT_OSC,
   input wire logic I_SYS_OSC,
   input wire logic I_WAKE,
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [2:0] I_HSIZE,
   input wire logic [31:0] I_HWDATA,
   input wire logic I_HREADY,
   output logic O_HREADYOUT,
   output logic [31:0] O_HRDATA,
   output logic O_HRESP,
   output logic O_CORE_RESET,
   output logic O_CPU_CLK_EN,
   output logic O_ADC_CLK_EN,
   output logic O_OSC_EN,
   output logic [2:0] O_CLK_SOURCE,
   output logic [1:0] O_LP_RANGE,
   output logic O_CLK_DIV8
);
   import cssq_pkg::*;

   cssq_top_s q; // registered state
   cssq_top_s next_q; // next state
   cssq_cfg_s cfg; // decode of the sampled fuses
   logic [SY_W-1:0] sy_level; // synchronised pin levels
   logic [SY_W-1:0] sy_rise; // synchronised rising edges
   logic rst_src; // any other reset source active
   logic [15:0] su_target; // start-up count for this pass
   logic bus_wr; // write data phase to a mapped word
   logic ctrl_pd; // power-down request this cycle
   logic ctrl_nr; // noise reduction request this cycle

   // the reset, brown-out and wake pins and both foreign clocks cross two flops first;
   // oscillators must stay below a third of the core clock
   cssq_sync #(
      .W(SY_W)
   ) u_sync (
      .i_clk(I_CORE_CLK),
      .i_rst(I_RST),
      .i_async({I_WAKE, I_SYS_OSC, I_WDT_OSC, I_BROWNOUT, I_EXT_RESET}),
      .o_level(sy_level),
      .o_rise(sy_rise)
   );

   // decode works on the snapshot, never on the live fuses
   cssq_fuse_decode #(
      .TOUT_LONG(TOUT_LONG),
      .SU_16K(SU_16K),
      .SU_32K(SU_32K)
   ) u_dec (
      .i_fuse(q.snap),
      .o_cfg(cfg)
   );

   // brown-out is one of the reset sources
   assign rst_src = sy_level[SY_EXT] | sy_level[SY_BOD];
   // 14 extra cycles only on the path from reset
   assign su_target = 16'(cfg.wake + (q.from_reset ? RST_EXTRA : 16'h0000));
   assign bus_wr = q.ap_valid & q.ap_write & q.ap_hit & q.ap_word;
   assign ctrl_pd = bus_wr & (q.ap_addr == OFS_CTRL) & I_HWDATA[CTRL_PDOWN];
   assign ctrl_nr = bus_wr & (q.ap_addr == OFS_CTRL) & I_HWDATA[CTRL_NOISE];

   // next state: bus slave, sequencer, outputs
   always_comb begin
      logic [31:0] rd;
      rd = 32'h0000_0000;
      next_q = q;
      // read mux, unmapped reads as zero
      if (q.ap_hit) begin
         unique case (q.ap_addr)
            OFS_FUSE: rd = 32'(q.fuse);
            OFS_STAT: rd = 32'({cfg.resv, q.range, q.div8, 1'b0, q.src, 1'b0, q.state});
            OFS_TOUT: rd = 32'(q.tout_cnt);
            OFS_SUCNT: rd = 32'(q.su_cnt);
            default: rd = 32'h0000_0000;
         endcase
      end
      // data phase of the previous address phase
      if (q.ap_valid && !q.ap_write) begin
         // reads take one wait state so the data comes from a flop
         next_q.hrdata = rd;
         next_q.hreadyout = 1'b1;
      end
      if (bus_wr && q.ap_addr == OFS_FUSE) begin
         // takes effect at the next start-up from reset only
         next_q.fuse = cssq_fuse_s'(I_HWDATA[6:0]);
      end
      next_q.ap_valid = 1'b0;
      // address phase capture
      if (q.hreadyout && I_HREADY && I_HSEL && I_HTRANS[1]) begin
         next_q.ap_valid = 1'b1;
         next_q.ap_write = I_HWRITE;
         next_q.ap_addr = I_HADDR[7:0];
         next_q.ap_hit = (I_HADDR[31:8] == 24'h00_0000);
         next_q.ap_word = (I_HSIZE == SIZE_WORD);
         if (!I_HWRITE) begin
            next_q.hreadyout = 1'b0;
         end
      end
      // start-up sequencer
      unique case (q.state)
         ST_HOLD: begin
            // only left for the time-out once all sources have released
            next_q.state = ST_TIMEOUT;
            next_q.snap = q.fuse;
            next_q.from_reset = 1'b1;
            next_q.tout_cnt = 14'h0000;
            next_q.su_cnt = 16'h0000;
         end
         ST_TIMEOUT: begin
            if (cfg.resv) begin
               next_q.state = ST_BADSEL;
            end else if (q.tout_cnt >= cfg.tout) begin
               // zero length falls straight through
               next_q.state = ST_STARTUP;
               next_q.su_cnt = 16'h0000;
            end else if (sy_rise[SY_WDT]) begin
               next_q.tout_cnt = 14'(q.tout_cnt + 14'h0001);
            end
         end
         ST_STARTUP: begin
            if (q.su_cnt >= su_target) begin
               next_q.state = ST_RUN;
            end else if (sy_rise[SY_OSC]) begin
               next_q.su_cnt = 16'(q.su_cnt + 16'h0001);
            end
         end
         ST_RUN: begin
            // power-down wins over noise reduction
            if (ctrl_pd) begin
               next_q.state = ST_PDOWN;
            end else if (ctrl_nr) begin
               next_q.state = ST_NOISE;
            end
         end
         ST_NOISE: begin
            // oscillator kept running, no count needed
            if (sy_rise[SY_WAKE]) begin
               next_q.state = ST_RUN;
            end
         end
         ST_PDOWN: begin
            // supply assumed good, so no time-out on wake
            if (sy_rise[SY_WAKE]) begin
               next_q.state = ST_STARTUP;
               next_q.from_reset = 1'b0;
               next_q.su_cnt = 16'h0000;
            end
         end
         ST_BADSEL: begin
            // stuck until a reset source fires again
            next_q.state = ST_BADSEL;
         end
      endcase
      // any reset source overrides and clears both counts
      if (rst_src) begin
         next_q.state = ST_HOLD;
         next_q.tout_cnt = 14'h0000;
         next_q.su_cnt = 16'h0000;
      end
      // state outputs follow the next state so they align with it; source, range and divide follow the fuse snapshot
      next_q.core_reset = next_q.state inside {ST_HOLD, ST_TIMEOUT, ST_STARTUP, ST_BADSEL};
      next_q.cpu_en = (next_q.state == ST_RUN);
      next_q.adc_en = next_q.state inside {ST_RUN, ST_NOISE};
      next_q.osc_en = (next_q.state != ST_PDOWN);
      next_q.src = cfg.src;
      next_q.range = cfg.range;
      next_q.div8 = ~q.snap.div8_n;
   end

   // one register for the whole state, shipped fuses at reset
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         q <= TOP_RESET;
      end else begin
         q <= next_q;
      end
   end

   // outputs straight from flops, O_HRESP tied low
   assign O_HREADYOUT = q.hreadyout;
   assign O_HRDATA = q.hrdata;
   assign O_HRESP = 1'b0;
   assign O_CORE_RESET = q.core_reset;
   assign O_CPU_CLK_EN = q.cpu_en;
   assign O_ADC_CLK_EN = q.adc_en;
   assign O_OSC_EN = q.osc_en;
   assign O_CLK_SOURCE = q.src;
   assign O_LP_RANGE = q.range;
   assign O_CLK_DIV8 = q.div8;

   // checks on the sequencer and the bus slave
   default clocking cb @(posedge I_CORE_CLK);
   endclocking
   default disable iff (I_RST);

   a_reset_src_restart: assert property (rst_src |=> q.state == ST_HOLD && q.su_cnt == 16'h0000)
      else $error("reset source did not restart the sequence");
   a_hold_release_snap: assert property (q.state == ST_HOLD && !rst_src |=> q.state == ST_TIMEOUT
      && q.from_reset && q.snap == $past(q.fuse))
      else $error("hold release did not start time-out with sampled fuses");
   a_snap_held_stable: assert property (q.state inside {ST_TIMEOUT, ST_STARTUP} |=> $stable(q.snap))
      else $error("fuse snapshot changed while counting");
   a_tout_count_exact: assert property (q.state == ST_STARTUP && q.from_reset |-> q.tout_cnt == cfg.tout)
      else $error("time-out left before full watchdog count");
   a_tout_zero_skip: assert property (q.state == ST_TIMEOUT && cfg.tout == 14'h0000 && !cfg.resv
      && !rst_src |=> q.state == ST_STARTUP)
      else $error("zero time-out did not skip");
   a_no_early_run: assert property (q.state == ST_STARTUP && q.su_cnt < su_target |=> q.state != ST_RUN)
      else $error("reset released before start-up count");
   a_run_after_count: assert property (q.state == ST_STARTUP && q.su_cnt >= su_target && !rst_src
      |=> q.state == ST_RUN && !O_CORE_RESET && O_CPU_CLK_EN)
      else $error("reset not released after start-up count");
   a_wake_no_timeout: assert property (q.state == ST_PDOWN && sy_rise[SY_WAKE] && !rst_src
      |=> q.state == ST_STARTUP && !q.from_reset && O_CORE_RESET)
      else $error("wake did not go to count only");
   a_wake_target_short: assert property (q.state == ST_STARTUP && !q.from_reset |-> su_target == cfg.wake)
      else $error("wake count includes reset extra");
   a_reserved_halt: assert property (q.state == ST_TIMEOUT && cfg.resv && !rst_src
      |=> q.state == ST_BADSEL && O_CORE_RESET ##1 O_CORE_RESET)
      else $error("reserved select not held in reset");
   a_adc_domain_on: assert property (q.state == ST_NOISE |-> O_ADC_CLK_EN && !O_CPU_CLK_EN)
      else $error("converter clock wrong in noise reduction");
   a_div8_polarity: assert property (q.state == ST_RUN |-> O_CLK_DIV8 == !q.snap.div8_n)
      else $error("divide by eight polarity wrong");
   a_source_routed: assert property (q.state == ST_RUN |-> O_CLK_SOURCE == cfg.src)
      else $error("selected source not routed");
   a_read_wait_one: assert property (q.hreadyout && I_HREADY && I_HSEL && I_HTRANS[1] && !I_HWRITE
      |=> !O_HREADYOUT ##1 O_HREADYOUT)
      else $error("read did not take exactly one wait state");

   c_reset_to_run: cover property (q.state == ST_STARTUP && q.from_reset ##1 q.state == ST_RUN);
   c_pdown_wake: cover property (q.state == ST_PDOWN ##1 q.state == ST_STARTUP);
   c_noise_wake: cover property (q.state == ST_NOISE ##1 q.state == ST_RUN);
   c_reserved_sel: cover property (q.state == ST_BADSEL);
endmodule
`default_nettype wire

// file: bench/cssq_osc_model.sv
// partner model: watchdog oscillator and selected system oscillator
`timescale 1ns/1ps
`default_nettype none
module cssq_osc_model #(
   parameter int WDT_HALF = 4, // core cycles per half watchdog period
   parameter int OSC_HALF = 5 // core cycles per half oscillator period
) (
   input wire logic i_clk,
   input wire logic i_osc_en,
   output logic o_wdt_osc,
   output logic o_sys_osc
);
   int wdt_cnt = 0; // half period counter, watchdog
   int osc_cnt = 0; // half period counter, oscillator
   logic wdt_q = 1'b0; // watchdog level, one driver only
   logic osc_q = 1'b0; // oscillator level, one driver only
   assign o_wdt_osc = wdt_q;
   assign o_sys_osc = osc_q;
   // watchdog oscillator runs free in every state
   always @(posedge i_clk) begin
      wdt_cnt <= (wdt_cnt == WDT_HALF - 1) ? 0 : wdt_cnt + 1;
      if (wdt_cnt == WDT_HALF - 1) begin
         wdt_q <= ~wdt_q;
      end
   end
   // crystal or resonator stands still while disabled
   always @(posedge i_clk) begin
      if (i_osc_en) begin
         osc_cnt <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
         if (osc_cnt == OSC_HALF - 1) begin
            osc_q <= ~osc_q;
         end
      end
   end
endmodule
`default_nettype wire

// file: bench/cssq_top_bench.sv
// testbench: clock source start-up sequencer
`timescale 1ns/1ps
`default_nettype none
module cssq_top_bench;
   import cssq_pkg::*;
   localparam logic [13:0] T_LONG = 14'h0020; // shortened long time-out
   localparam logic [15:0] S_16K = 16'h0040; // shortened crystal count
   localparam logic [15:0] S_32K = 16'h0080; // shortened watch crystal count
   localparam int WP = 8; // watchdog period in core cycles
   localparam int SP = 10; // oscillator period in core cycles
   typedef struct packed {
      logic [6:0] fuse;
      logic [2:0] src;
      logic [1:0] range;
      logic [15:0] tout;
      logic [15:0] wake;
   } cssq_case_s;
   // fuse image, expected source, range, time-out and wake counts
   cssq_case_s tbl [10] = '{
      '{7'h42, 3'h4, 2'h0, 16'h0000, 16'h0006}, '{7'h53, 3'h3, 2'h0, 16'h0200, 16'h0006},
      '{7'h40, 3'h5, 2'h0, 16'h0000, 16'h0006}, '{7'h48, 3'h0, 2'h0, 16'h0200, 16'h0102},
      '{7'h6B, 3'h0, 2'h1, 16'h0200, S_16K}, '{7'h2D, 3'h0, 2'h2, 16'h0200, S_16K},
      '{7'h6E, 3'h0, 2'h3, 16'h0000, 16'h0400}, '{7'h4F, 3'h0, 2'h3, 16'(T_LONG), 16'h0400},
      '{7'h56, 3'h1, 2'h0, 16'(T_LONG), 16'h0102}, '{7'h45, 3'h2, 2'h0, 16'h0000, S_32K}};
   // reserved selections; 0001 last, the only one that names no source
   logic [6:0] resv [3] = '{7'h72, 7'h74, 7'h41};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ext_rst = 1'b0;
   logic brownout_detector = 1'b0;
   logic wake = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = '0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = '0;
   logic [31:0] hwdata = '0;
   logic hreadyout, hresp, core_rst, cpu_en, adc_en, osc_en, div8, wdt_osc, sys_osc;
   logic [31:0] hrdata;
   logic [2:0] src;
   logic [1:0] range;
   logic [31:0] rd; // last read data
   int n_mismatch = 0;
   int checks = 0;
   int cycles = 0; // free running cycle stamp
   int cyc; // measured start-up length
   int t0; // stamp of a reset release
   always #25 clk = ~clk; // 20 MHz core clock
   cssq_top #(.TOUT_LONG(T_LONG), .SU_16K(S_16K), .SU_32K(S_32K)) uut (
      .I_CORE_CLK(clk), .I_RST(rst), .I_EXT_RESET(ext_rst), .I_BROWNOUT(brownout_detector),
      .I_WDT_OSC(wdt_osc), .I_SYS_OSC(sys_osc), .I_WAKE(wake), .I_HSEL(hsel),
      .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
      .I_HWDATA(hwdata), .I_HREADY(hreadyout), .O_HREADYOUT(hreadyout), .O_HRDATA(hrdata),
      .O_HRESP(hresp), .O_CORE_RESET(core_rst), .O_CPU_CLK_EN(cpu_en), .O_ADC_CLK_EN(adc_en),
      .O_OSC_EN(osc_en), .O_CLK_SOURCE(src), .O_LP_RANGE(range), .O_CLK_DIV8(div8));
   cssq_osc_model #(.WDT_HALF(WP / 2), .OSC_HALF(SP / 2)) osc (
      .i_clk(clk), .i_osc_en(osc_en), .o_wdt_osc(wdt_osc), .o_sys_osc(sys_osc));
   // compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   // one single word transfer; address phase held until the slave is ready
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= SIZE_WORD;
      haddr <= {24'h0, a};
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      q = hrdata;
      check({31'h0, hresp}, 32'h0);
   endtask
   // wait for the run state, bounded
   task automatic wait_run(input int limit);
      while (cpu_en !== 1'b1 && cycles - t0 < limit) @(posedge clk);
      cyc = cycles - t0;
   endtask
   // measured length must sit from 20 below to 40 above the expected length in core cycles
   task automatic span(input int exp);
      check(32'(cyc >= exp - 20 && cyc <= exp + 40), 32'h1);
   endtask
   // program the fuses and restart through the external reset source
   task automatic boot(input logic [6:0] f, input int limit);
      xfer(1'b1, OFS_FUSE, {25'h0, f}, rd);
      ext_rst <= 1'b1;
      repeat (6) @(posedge clk);
      ext_rst <= 1'b0;
      t0 = cycles;
      wait_run(limit);
   endtask
   // closing report
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // hang guard, about a sixth above the expected run of some 69000 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         n_mismatch++;
         conclude();
      end
   end
   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      check({29'h0, core_rst, cpu_en, osc_en}, 32'h5);
      rst <= 1'b0;
      t0 = cycles;
      wait_run(5000);
      span(int'(T_LONG) * WP + 20 * SP);
      xfer(1'b0, OFS_FUSE, '0, rd);
      check(rd, 32'h22);
      xfer(1'b0, OFS_STAT, '0, rd);
      check(rd, 32'h143);
      xfer(1'b0, 8'h14, '0, rd);
      check(rd, 32'h0);
      $display("test default boot done");
      foreach (tbl[i]) begin
         boot(tbl[i].fuse, 20000);
         span(int'(tbl[i].tout) * WP + (int'(tbl[i].wake) + 14) * SP);
         xfer(1'b0, OFS_STAT, '0, rd);
         check(rd, {20'h0, 1'b0, tbl[i].range, ~tbl[i].fuse[6], 1'b0, tbl[i].src, 1'b0, 3'h3});
         check({26'h0, div8, range, src}, {26'h0, ~tbl[i].fuse[6], tbl[i].range, tbl[i].src});
      end
      $display("test fuse table done");
      xfer(1'b1, OFS_CTRL, 32'h1, rd);
      repeat (3) @(posedge clk);
      check({29'h0, osc_en, cpu_en, adc_en}, 32'h0);
      wake <= 1'b1;
      t0 = cycles;
      wait_run(5000);
      wake <= 1'b0;
      span(int'(S_32K) * SP);
      xfer(1'b1, OFS_CTRL, 32'h2, rd);
      repeat (3) @(posedge clk);
      check({29'h0, osc_en, cpu_en, adc_en}, 32'h5);
      wake <= 1'b1;
      t0 = cycles;
      wait_run(20);
      wake <= 1'b0;
      check(32'(cyc < 20), 32'h1);
      $display("test sleep modes done");
      xfer(1'b1, OFS_FUSE, 32'h53, rd);
      ext_rst <= 1'b1;
      repeat (6) @(posedge clk);
      ext_rst <= 1'b0;
      repeat (1000) @(posedge clk);
      // time-out must be part way through before the brown-out hits
      xfer(1'b0, OFS_TOUT, '0, rd);
      check(32'(rd != 32'h0), 32'h1);
      brownout_detector <= 1'b1;
      repeat (4) @(posedge clk);
      xfer(1'b0, OFS_TOUT, '0, rd);
      check(rd, 32'h0);
      check({31'h0, core_rst}, 32'h1);
      brownout_detector <= 1'b0;
      t0 = cycles;
      repeat (10) @(posedge clk);
      xfer(1'b1, OFS_FUSE, 32'h42, rd);
      wait_run(8000);
      span(512 * WP + 20 * SP);
      check({29'h0, src}, 32'h3);
      $display("test mid-sequence reset done");
      foreach (resv[i]) begin
         boot(resv[i], 5000);
         xfer(1'b0, OFS_STAT, '0, rd);
         check({27'h0, core_rst, rd[11], rd[2:0]}, 32'h1E);
      end
      check({29'h0, src}, 32'h6);
      $display("test reserved codes done");
      conclude();
   end
endmodule
`default_nettype wire
